// [bst_tap.sv]
// Boundary-scan test access port: controller, instruction, bypass, ID and boundary registers.
//
// Overview of operation
// R1 - Sample inputs on rise, update outputs on fall.
// R2 - Mode select steers controller; undriven reads high.
// R3 - Undriven serial input reads high.
// R4 - Exactly one data register chosen by instruction.
// R5 - Shift in at MSB, out at LSB.
// R6 - Serial output driven only while shifting.
// R7 - Five high mode-select edges reach reset.
// R8 - Power-up reset keeps serial output floating.
// R9 - Unused port: hold test clock low.
// R10 - Three-bit instruction register loaded serially.
// R11 - Identification instruction at power-up and reset.
// R12 - Instruction capture loads low bits with 01.
// R13 - One-bit bypass register cleared on capture.
// R14 - Boundary register captures ring, shifts in data-shift.
// R15 - Ring capture under external test and sample instructions.
// R16 - Identification register captures fixed 32-bit code.
// R17 - New instruction takes effect at instruction update.
// R18 - Bypass instruction routes data through bypass bit.
// R19 - External test drives preloaded values onto pins.
// R20 - Standard sixteen-state controller, one step per rise.
module bst_tap
    import bst_pkg::*;
(
    input  wire logic          clk_sys,
    input  wire logic          rstn,
    input  wire logic          testClk,
    input  wire logic          modeSel,
    input  wire logic          modeSelDriven,
    input  wire logic          dataIn,
    input  wire logic          dataInDriven,
    input  wire bst_ring_type  ring,
    output bst_drive_type      drive,
    output logic               dataOut,
    output logic               dataOutEn_n
);

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    logic [1:0] clkSync_reg;
    logic [1:0] tmsSync_reg;
    logic [1:0] tdiSync_reg;
    logic       clkLast_reg;

    // Two flip-flops on the clock, mode-select and data pins; the ring input is captured without them.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            clkSync_reg <= 2'h0;
            tmsSync_reg <= 2'h3;
            tdiSync_reg <= 2'h3;
            clkLast_reg <= 1'h0;
        end else begin
            clkSync_reg <= {clkSync_reg[0], testClk};
            tmsSync_reg <= {tmsSync_reg[0], modeSel | ~modeSelDriven}; // R2
            tdiSync_reg <= {tdiSync_reg[0], dataIn | ~dataInDriven};   // R3
            clkLast_reg <= clkSync_reg[1];
        end
    end

    // Edge strobes of the test clock; a held-low clock never advances.
    wire riseEn = clkSync_reg[1] & ~clkLast_reg; // R1 R9
    wire fallEn = ~clkSync_reg[1] & clkLast_reg; // R1
    wire tms    = tmsSync_reg[1];
    wire tdi    = tdiSync_reg[1];

    // ------------------------------------------------------------------
    // Controller state machine
    // ------------------------------------------------------------------
    bst_state_type state_reg;
    bst_state_type state_next;

    // Standard sixteen-state transition table.
    always_comb begin
        case (state_reg)
            ST_RESET:  state_next = tms ? ST_RESET  : ST_IDLE; // R20
            ST_IDLE:   state_next = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: state_next = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: state_next = tms ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR:  state_next = tms ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: state_next = tms ? ST_UPD_DR : ST_PAU_DR;
            ST_PAU_DR: state_next = tms ? ST_EX2_DR : ST_PAU_DR;
            ST_EX2_DR: state_next = tms ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: state_next = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: state_next = tms ? ST_RESET  : ST_CAP_IR; // R7
            ST_CAP_IR: state_next = tms ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR:  state_next = tms ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: state_next = tms ? ST_UPD_IR : ST_PAU_IR;
            ST_PAU_IR: state_next = tms ? ST_EX2_IR : ST_PAU_IR;
            ST_EX2_IR: state_next = tms ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: state_next = tms ? ST_SEL_DR : ST_IDLE;
            default:   state_next = ST_RESET;
        endcase
    end

    // State advances only on a sampled rising test-clock edge.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_reg <= ST_RESET; // R8
        end else if (riseEn) begin
            state_reg <= state_next; // R20
        end
    end

    // ------------------------------------------------------------------
    // State decodes and register selection
    // ------------------------------------------------------------------
    logic [IR_WIDTH-1:0] irShift_reg;
    logic [IR_WIDTH-1:0] irActive_reg;

    wire toReset  = (state_next == ST_RESET); // R11
    wire capDr    = (state_reg == ST_CAP_DR);
    wire shDr     = (state_reg == ST_SH_DR);
    wire updDr    = (state_reg == ST_UPD_DR);
    wire capIr    = (state_reg == ST_CAP_IR);
    wire shIr     = (state_reg == ST_SH_IR);
    wire updIr    = (state_reg == ST_UPD_IR);
    wire selId    = (irActive_reg == INS_IDCODE);
    wire selExt   = (irActive_reg == INS_EXTEST);
    wire selSampZ = (irActive_reg == INS_SAMPLEZ);
    wire selBsr   = selExt | selSampZ | (irActive_reg == INS_SAMPLE);     // R15
    wire selByp   = ~selId & ~selBsr;                                     // R4 R18

    // ------------------------------------------------------------------
    // Instruction register
    // ------------------------------------------------------------------
    // Shift stage captures 01 in its low bits; the active copy changes at update.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            irShift_reg  <= INS_IDCODE;
            irActive_reg <= INS_IDCODE; // R11
        end else if (riseEn) begin
            if (toReset) begin
                irActive_reg <= INS_IDCODE; // R11
            end else if (capIr) begin
                irShift_reg <= {irShift_reg[IR_WIDTH-1], IR_CAPTURE_LOW}; // R12
            end else if (shIr) begin
                irShift_reg <= {tdi, irShift_reg[IR_WIDTH-1:1]}; // R5 R10
            end else if (updIr) begin
                irActive_reg <= irShift_reg; // R17
            end
        end
    end

    // ------------------------------------------------------------------
    // Data registers
    // ------------------------------------------------------------------
    logic                 bypass_reg;
    logic [ID_WIDTH-1:0]  idShift_reg;
    logic [BSR_WIDTH-1:0] bsrShift_reg;
    logic [BSR_WIDTH-1:0] bsrHold_reg;

    // Bypass bit clears on capture and shifts one stage.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            bypass_reg <= 1'h0;
        end else if (riseEn && selByp) begin
            if (capDr) begin
                bypass_reg <= 1'h0; // R13
            end else if (shDr) begin
                bypass_reg <= tdi; // R18
            end
        end
    end

    // Identification register loads the hardwired code and shifts toward the LSB.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            idShift_reg <= ID_CODE_VALUE;
        end else if (riseEn && selId) begin
            if (capDr) begin
                idShift_reg <= ID_CODE_VALUE; // R16
            end else if (shDr) begin
                idShift_reg <= {tdi, idShift_reg[ID_WIDTH-1:1]}; // R5
            end
        end
    end

    // Boundary register snapshots the ring, shifts, and latches at update.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            bsrShift_reg <= '0;
            bsrHold_reg  <= {1'h1, {(BSR_WIDTH-1){1'h0}}};
        end else if (riseEn) begin
            if (toReset) begin
                bsrHold_reg[OE_CELL] <= 1'h1; // R7
            end else if (selBsr && capDr) begin
                bsrShift_reg <= {1'h1, {(BSR_WIDTH-1-RING_IN-RING_OUT){1'h0}}, ring}; // R14 R15
            end else if (selBsr && shDr) begin
                bsrShift_reg <= {tdi, bsrShift_reg[BSR_WIDTH-1:1]}; // R5 R14
            end else if (selBsr && updDr) begin
                bsrHold_reg <= bsrShift_reg;
            end
        end
    end

    // ------------------------------------------------------------------
    // Serial output and pin drive
    // ------------------------------------------------------------------
    wire drBit = selId ? idShift_reg[0] : (selBsr ? bsrShift_reg[0] : bypass_reg); // R4
    wire soBit = shIr ? irShift_reg[0] : drBit;

    // Serial output moves only on falling edges and floats outside shift states.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            dataOut     <= 1'h0;
            dataOutEn_n <= 1'h1; // R8
        end else if (fallEn) begin
            dataOut     <= soBit;         // R1 R6
            dataOutEn_n <= ~(shIr | shDr); // R6
        end
    end

    // Pin override from the held boundary cells; sample-Z floats the bus.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            drive <= '0;
        end else if (fallEn) begin
            drive.overrideEn <= selExt | selSampZ;
            drive.outData    <= bsrHold_reg[RING_OUT-1:0]; // R19
            drive.outDriveEn <= selExt & bsrHold_reg[OE_CELL]; // R19
        end
    end

endmodule

// [bst_pkg.sv]
// Package with constants and types for the boundary-scan test access port.
package bst_pkg;

    // ------------------------------------------------------------------
    // Register sizes
    // ------------------------------------------------------------------
    localparam int IR_WIDTH   = 3;
    localparam int ID_WIDTH   = 32;
    localparam int BSR_WIDTH  = 90;
    localparam int RING_IN    = 45;
    localparam int RING_OUT   = 36;
    localparam int OE_CELL    = 89;

    // ------------------------------------------------------------------
    // Instruction codes (three-bit instruction register)
    // ------------------------------------------------------------------
    localparam logic [2:0] INS_EXTEST  = 3'h0;
    localparam logic [2:0] INS_IDCODE  = 3'h1;
    localparam logic [2:0] INS_SAMPLEZ = 3'h2;
    localparam logic [2:0] INS_SAMPLE  = 3'h4;
    localparam logic [2:0] INS_BYPASS  = 3'h7;

    // Fixed capture pattern for the two low instruction bits.
    localparam logic [1:0] IR_CAPTURE_LOW = 2'h1;

    // Identification code; the value is arbitrary.
    localparam logic [31:0] ID_CODE_VALUE = 32'h0A5C_3001;

    // Consecutive mode-select highs that force the reset state.
    localparam logic [2:0] TMS_RESET_COUNT = 3'h5;

    // ------------------------------------------------------------------
    // Controller states, one-hot
    // ------------------------------------------------------------------
    typedef enum logic [15:0] {
        ST_RESET   = 16'h0001,
        ST_IDLE    = 16'h0002,
        ST_SEL_DR  = 16'h0004,
        ST_CAP_DR  = 16'h0008,
        ST_SH_DR   = 16'h0010,
        ST_EX1_DR  = 16'h0020,
        ST_PAU_DR  = 16'h0040,
        ST_EX2_DR  = 16'h0080,
        ST_UPD_DR  = 16'h0100,
        ST_SEL_IR  = 16'h0200,
        ST_CAP_IR  = 16'h0400,
        ST_SH_IR   = 16'h0800,
        ST_EX1_IR  = 16'h1000,
        ST_PAU_IR  = 16'h2000,
        ST_EX2_IR  = 16'h4000,
        ST_UPD_IR  = 16'h8000
    } bst_state_type;

    // System side of the I/O ring.
    typedef struct packed {
        logic [RING_IN-1:0]  pinIn;
        logic [RING_OUT-1:0] pinOut;
    } bst_ring_type;

    // Values driven back onto the system pins.
    typedef struct packed {
        logic                overrideEn;
        logic [RING_OUT-1:0] outData;
        logic                outDriveEn;
    } bst_drive_type;

endpackage

// [bst_tap_properties.sv]
// Checker of output timing and reset behaviour of the test access port.
module bst_tap_properties import bst_pkg::*; (
    input wire logic          clk_sys,
    input wire logic          rstn,
    input wire logic          testClk,
    input wire logic          modeSel,
    input wire logic          modeSelDriven,
    input wire bst_drive_type drive,
    input wire logic          dataOut,
    input wire logic          dataOutEn_n
);
    logic [2:0] low_reg;
    logic [2:0] high_reg;
    logic       prev_reg;
    // Rises and mode select as the port reads them, pull-up included.
    wire        rise      = testClk & ~prev_reg;
    wire        tms       = modeSel | ~modeSelDriven;
    wire [2:0]  low_next  = testClk ? 3'h0 : low_reg + {2'h0, low_reg != 3'h7};
    wire [2:0]  high_next = !rise ? high_reg : !tms ? 3'h0
                          : high_reg + {2'h0, high_reg != TMS_RESET_COUNT};
    // Counts low clock cycles and consecutive high mode-select rises.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            low_reg  <= 3'h0;
            high_reg <= 3'h0;
            prev_reg <= 1'b0;
        end else begin
            low_reg  <= low_next;
            high_reg <= high_next;
            prev_reg <= testClk;
        end
    end
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    a_reset_float: assert property ($rose(rstn) |-> dataOutEn_n && drive == '0)
        else $error("output active after reset");
    a_data_on_fall: assert property ($changed(dataOut) |-> !testClk && !$past(testClk, 2))
        else $error("data moved off a fall");
    a_enable_on_fall: assert property ($changed(dataOutEn_n) |-> !testClk && !$past(testClk, 2))
        else $error("enable moved off a fall");
    a_drive_on_fall: assert property ($changed(drive) |-> !testClk && !$past(testClk, 2))
        else $error("pin drive moved off a fall");
    a_stopped_quiet: assert property (low_reg == 3'h7 |->
        $stable(dataOut) && $stable(dataOutEn_n) && $stable(drive))
        else $error("output moved with clock stopped");
    a_enable_needs_override: assert property (drive.outDriveEn |-> drive.overrideEn)
        else $error("pins enabled without override");
    a_five_high_float: assert property (high_reg == TMS_RESET_COUNT |-> dataOutEn_n)
        else $error("output driven after reset sequence");
    a_five_high_release: assert property (high_reg == TMS_RESET_COUNT && low_reg == 3'h4 |->
        !drive.overrideEn && !drive.outDriveEn)
        else $error("override kept after reset sequence");
endmodule
bind bst_tap bst_tap_properties u_props (.clk_sys(clk_sys), .rstn(rstn), .testClk(testClk),
    .modeSel(modeSel), .modeSelDriven(modeSelDriven), .drive(drive), .dataOut(dataOut),
    .dataOutEn_n(dataOutEn_n));

// [bst_ctl_model.sv]
// Scan controller model that clocks the test port and walks its states.
module bst_ctl_model (
    output logic      testClk,
    output logic      modeSel,
    output logic      modeSelDriven,
    output logic      dataIn,
    output logic      dataInDriven,
    input  wire logic dataOut,
    input  wire logic dataOutEn_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic floatTms = 1'b0;
    logic floatTdi = 1'b0;
    // The clock rests low between frames so the port never advances.
    initial begin
        testClk       = 1'b0;
        modeSel       = 1'b1;
        modeSelDriven = 1'b1;
        dataIn        = 1'b1;
        dataInDriven  = 1'b1;
    end
    // One period; a released line toggles so only a pull-up reads steady high.
    task automatic step(input logic tms, input logic tdi, output logic tdo, output logic oen);
        #40;
        modeSelDriven = ~floatTms;
        modeSel       = floatTms ? ~modeSel : tms;
        dataInDriven  = ~floatTdi;
        dataIn        = floatTdi ? ~dataIn : tdi;
        #40;
        tdo = dataOut;
        oen = dataOutEn_n;
        #20;
        testClk = 1'b1;
        #60;
        testClk = 1'b0;
    endtask
    // From idle through capture and shift, then update and back to idle.
    task automatic shift(input logic ir, input int n, input logic [89:0] din,
                         output logic [89:0] dout, output logic oeBad);
        logic t;
        logic o;
        dout  = '0;
        oeBad = 1'b0;
        step(1'b1, 1'b1, t, o);
        if (ir)
            step(1'b1, 1'b1, t, o);
        repeat (2) step(1'b0, 1'b1, t, o);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], dout[i], o);
            oeBad |= o;
        end
        step(1'b1, 1'b1, t, o);
        oeBad |= ~o;
        step(1'b0, 1'b1, t, o);
    endtask
endmodule

// [bst_tap_tb.sv]
// Self-checking bench for the boundary-scan test access port.
module bst_tap_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import bst_pkg::*;
    logic          clk_sys, rstn, testClk, modeSel, modeSelDriven;
    logic          dataIn, dataInDriven, dataOut, dataOutEn_n;
    bst_ring_type  ring;
    bst_drive_type drive;
    int            errCount = 0, cmpCount = 0, cycles = 0;
    bst_tap u_dut (.clk_sys(clk_sys), .rstn(rstn), .testClk(testClk), .modeSel(modeSel),
        .modeSelDriven(modeSelDriven), .dataIn(dataIn), .dataInDriven(dataInDriven),
        .ring(ring), .drive(drive), .dataOut(dataOut), .dataOutEn_n(dataOutEn_n));
    bst_ctl_model u_ctl (.testClk(testClk), .modeSel(modeSel), .modeSelDriven(modeSelDriven),
        .dataIn(dataIn), .dataInDriven(dataInDriven), .dataOut(dataOut), .dataOutEn_n(dataOutEn_n));
    // Compares one value and reports a difference.
    task automatic check(input string name, input logic [89:0] seen, input logic [89:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            errCount++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Prints the verdict and ends the run.
    task automatic conclude();
        if (errCount == 0 && cmpCount > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Loads an instruction and checks the captured pattern.
    task automatic load_ir(input logic [2:0] ins);
        logic [89:0] q;
        logic        b;
        u_ctl.shift(1'b1, 3, {87'h0, ins}, q, b);
        repeat (4) @(negedge clk_sys); // Lets the new instruction reach the pin drive.
        check("ircap", q[1:0], IR_CAPTURE_LOW);
        check("iroe", b, 1'b0);
    endtask
    // After power-up the output floats and the fixed code reads back.
    task automatic t_idcode();
        logic [89:0] q;
        logic        b;
        check("oe", dataOutEn_n, 1'b1);
        check("drive", drive, '0);
        u_ctl.step(1'b0, 1'b1, b, b);
        u_ctl.shift(1'b0, 32, '0, q, b);
        check("id", q[31:0], ID_CODE_VALUE);
        check("shiftoe", b, 1'b0);
    endtask
    // Each bypass-selecting code leaves one cleared bit in the path.
    task automatic t_bypass();
        logic [89:0] q;
        logic        b;
        logic [2:0]  codes [4] = '{3'h3, 3'h5, 3'h6, INS_BYPASS};
        foreach (codes[i]) begin
            load_ir(codes[i]);
            u_ctl.shift(1'b0, 4, 90'hB, q, b);
            check("bypass", q[3:0], 4'h6);
        end
    endtask
    // Ring capture under each capturing code, preload and pin drive.
    task automatic t_bsr();
        logic [89:0] q;
        logic [89:0] pre;
        logic        b;
        logic [2:0]  codes [3] = '{INS_SAMPLE, INS_EXTEST, INS_SAMPLEZ};
        pre = {1'b1, 53'h0, 36'hC_5A5A_A5A5};
        foreach (codes[i]) begin
            load_ir(codes[i]);
            if (codes[i] == INS_EXTEST)
                check("extest", drive, {1'b1, pre[35:0], 1'b1});
            ring = {ring[79:0], ~ring[80]};
            u_ctl.shift(1'b0, 90, pre, q, b);
            check("capture", q[80:0], ring);
        end
        check("samplez", {drive.overrideEn, drive.outDriveEn}, 2'h2);
    endtask
    // Released mode select and data lines read high and reset the port.
    task automatic t_float();
        logic [89:0] q;
        logic        b;
        u_ctl.floatTms = 1'b1;
        u_ctl.floatTdi = 1'b1;
        repeat (5) u_ctl.step(1'b0, 1'b0, b, b);
        u_ctl.floatTms = 1'b0;
        u_ctl.step(1'b0, 1'b0, b, b);
        check("release", {drive.overrideEn, drive.outDriveEn}, 2'h0);
        u_ctl.shift(1'b0, 64, '0, q, b);
        check("idfloat", q[63:0], {32'hFFFF_FFFF, ID_CODE_VALUE});
    endtask
    // System clock.
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    // Cuts a hung run short.
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            errCount++;
            conclude();
        end
    end
    // Main sequence.
    initial begin
        rstn = 1'b0;
        ring = {9'h1A5, 36'h9_6969_6969, 36'hC_3C3C_3C3C};
        repeat (6) @(negedge clk_sys);
        rstn = 1'b1;
        repeat (4) @(negedge clk_sys);
        t_idcode();
        t_bypass();
        t_bsr();
        t_float();
        conclude();
    end
endmodule
